/* logic/ssf_regs.svh */
`ifndef SSF_REGS_SVH
`define SSF_REGS_SVH

// Byte offsets on the register bus
`define SSF_STATUS_OFS   4'h0
`define SSF_CONFIG_OFS   4'h4

// Status register fields
`define SSF_TX_EMPTY_BIT 7
`define SSF_RX_FULL_BIT  6
`define SSF_OVERRUN_BIT  5
`define SSF_FRAMING_BIT  4
`define SSF_PARITY_BIT   3
`define SSF_TX_DONE_BIT  2
`define SSF_RX_ADDR_BIT  1
`define SSF_TX_ADDR_BIT  0

// Configuration register fields
`define SSF_CFG_TX_ON    0
`define SSF_CFG_RX_ON    1
`define SSF_CFG_SYNC     2
`define SSF_CFG_PAR_ON   3
`define SSF_CFG_PAR_ODD  4
`define SSF_CFG_MULTI    5

// Reset values
`define SSF_STATUS_RST   8'h84
`define SSF_CONFIG_RST   8'h00

// Bus answers
`define SSF_RESP_OKAY    2'h0
`define SSF_RESP_SLVERR  2'h2

`endif

/* logic/ssf_pkg.sv */
package ssf_pkg;

    // One received character as framed on the line
    typedef logic [7:0] ssf_byte_type;

    // Verdict on one finished character
    typedef struct packed {
        logic         done;
        ssf_byte_type char_data;
        logic         framing;
        logic         parity;
        logic         addr_bit;
    } ssf_verdict_type;

endpackage

/* logic/ssf_rx_if.sv */
`timescale 1ns/1ps
interface ssf_rx_if;
    import ssf_pkg::*;

    logic            done;        // Character finished, reception allowed
    ssf_byte_type    char_data;   // Received data bits
    logic            parity_bit;  // Received parity bit
    logic            stop_bit;    // First sampled stop bit
    logic            addr_bit;    // Multiprocessor bit of the character
    logic            sync_mode;   // Synchronous mode selected
    logic            par_on;      // Parity checking enabled
    logic            par_odd;     // Odd parity selected
    ssf_verdict_type verdict;     // Registered result

    modport top (
        output done, char_data, parity_bit, stop_bit, addr_bit,
        output sync_mode, par_on, par_odd,
        input  verdict
    );
    modport check (
        input  done, char_data, parity_bit, stop_bit, addr_bit,
        input  sync_mode, par_on, par_odd,
        output verdict
    );
endinterface

/* logic/ssf_rx_check.sv */
`timescale 1ns/1ps
module ssf_rx_check
    import ssf_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // Character in, verdict out
    ssf_rx_if.check   rx
);

    // Ones in data plus parity, odd when set
    wire logic ones_odd;
    // Framing and parity faults of this character
    wire logic fault_frame;
    wire logic fault_par;
    ssf_verdict_type verdict_q;

    assign ones_odd    = ^{rx.char_data, rx.parity_bit};
    // Only the first stop bit is looked at; a second one is never checked
    assign fault_frame = ~rx.sync_mode & ~rx.stop_bit;
    // Even wants an even count, odd wants an odd count
    assign fault_par   = ~rx.sync_mode & rx.par_on
                       & (ones_odd ^ rx.par_odd);

    // Register the verdict so the flag logic sees a clean one-cycle pulse
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            verdict_q <= '0;
        end else begin
            verdict_q.done      <= rx.done;
            verdict_q.char_data <= rx.char_data;
            verdict_q.framing   <= rx.done & fault_frame;
            verdict_q.parity    <= rx.done & fault_par;
            verdict_q.addr_bit  <= rx.addr_bit;
        end
    end

    assign rx.verdict = verdict_q;

endmodule // ssf_rx_check

/* logic/ssf_status.sv */
// How it works
// - Eight-bit status loads 84h on reset, standby
// - Only zero writes clear flags, after read
// - Bits 2,1 read-only; bit 0 read-write
// - Tx-empty sets: reset, standby, disable, shift load
// - Tx-empty clears by read-set then write zero
// - Rx-full sets on clean character transfer
// - Errors, receiver disable keep data, rx-full
// - Overrun on character while full; discard it
// - Overrun halts receive; sync also transmit
// - Receiver disable keeps overrun and framing
// - Async stop bit zero sets framing flag
// - Two stop bits: check first only
// - Framing error stores character, no rx-full
// - Framing flag halts receive; sync transmit
// - Parity mismatch sets parity flag in async
// - Receive flags clear: reset, standby, read-write
// - Parity error stores character, halts reception
// - Tx-finished sets: reset, standby, disable, idle end
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "ssf_regs.svh"
module ssf_status
    import ssf_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic              standby,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output wire logic              s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output wire logic              s_axi_wready,
    // AXI4-Lite write response
    output wire logic [1:0]        s_axi_bresp,
    output wire logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output wire logic              s_axi_arready,
    // AXI4-Lite read data
    output wire logic [31:0]       s_axi_rdata,
    output wire logic [1:0]        s_axi_rresp,
    output wire logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Transmit shift register events
    input  wire logic              tx_load,
    input  wire logic              tx_last_bit,
    // Receive shift register events
    input  wire logic              rx_done,
    input  wire logic [7:0]        rx_char,
    input  wire logic              rx_parity_bit,
    input  wire logic              rx_stop_bit,
    input  wire logic              rx_mpb,
    // State toward the line logic
    output wire logic [7:0]        rx_data,
    output wire logic              rx_halt,
    output wire logic              tx_halt,
    output wire logic              tx_on,
    output wire logic              rx_on,
    output wire logic              sync_mode,
    output wire logic              tx_addr_flag,
    output wire logic              tx_buffer_empty
);

    // Next flag value: a set in the same cycle beats a clear
    function automatic logic flag_next(input logic q,
                                       input logic set,
                                       input logic clr);
        flag_next = set | (q & ~clr);
    endfunction

    ssf_rx_if rx_link ();

    // Status flags
    logic       tx_empty_q;         // Transmit buffer empty
    logic       rx_full_q;          // Receive buffer full
    logic       overrun_q;          // Overrun error
    logic       framing_q;          // Framing error
    logic       parity_q;           // Parity error
    logic       tx_done_q;          // Transmission finished
    logic       rx_addr_q;          // Received address bit
    logic       tx_addr_q;          // Address bit to send
    logic [7:3] seen_q;             // Flags seen set by a read
    logic [7:0] config_q;           // Own configuration register
    logic [7:0] rx_data_q;          // Receive data register

    // Bus slave holding registers
    logic              aw_q;        // Write address held
    logic [ADDR_W-1:0] awaddr_q;    // Held write address
    logic              w_q;         // Write data held
    logic [31:0]       wdata_q;     // Held write data
    logic [3:0]        wstrb_q;     // Held byte enables
    logic              bvalid_q;    // Write response pending
    logic [1:0]        bresp_q;     // Write response code
    logic              rvalid_q;    // Read data pending
    logic [31:0]       rdata_q;     // Read data
    logic [1:0]        rresp_q;     // Read response code

    // Bus decode
    wire logic       wr_fire;       // Both halves of a write present
    wire logic       rd_fire;       // Read address taken
    wire logic       wr_status;     // Write hits status byte
    wire logic       wr_config;     // Write hits config byte
    wire logic       wr_mapped;     // Write address is mapped
    wire logic       rd_status;     // Read of status register
    wire logic       rd_mapped;     // Read address is mapped
    wire logic [7:0] status_byte;   // Assembled status register
    wire logic [7:3] clr_req;       // Granted clears of event flags
    wire logic [7:3] seen_set;      // Flags observed set by a read
    wire logic       std_off;       // Reset-value force from standby

    // Receive verdict decode
    wire logic       rx_active;     // Reception allowed this cycle
    wire logic       store_ev;      // Character enters data register
    wire logic       overrun_ev;    // Character lost to overrun
    wire logic       full_ev;       // Clean character transferred
    wire logic       tx_off;        // Transmitter disabled

    // Handshake: one write and one read in flight at most
    assign s_axi_awready = ~aw_q;
    assign s_axi_wready  = ~w_q;
    assign s_axi_arready = ~rvalid_q;
    assign wr_fire       = aw_q & w_q & ~bvalid_q;
    assign rd_fire       = s_axi_arvalid & ~rvalid_q;

    // Address decode on byte offsets
    assign wr_status = wr_fire & (awaddr_q == `SSF_STATUS_OFS) & wstrb_q[0];
    assign wr_config = wr_fire & (awaddr_q == `SSF_CONFIG_OFS) & wstrb_q[0];
    assign wr_mapped = (awaddr_q == `SSF_STATUS_OFS)
                     | (awaddr_q == `SSF_CONFIG_OFS);
    assign rd_status = rd_fire & (s_axi_araddr == `SSF_STATUS_OFS);
    assign rd_mapped = (s_axi_araddr == `SSF_STATUS_OFS)
                     | (s_axi_araddr == `SSF_CONFIG_OFS);

    // Status byte as software sees it
    assign status_byte = {tx_empty_q, rx_full_q, overrun_q, framing_q,
                          parity_q, tx_done_q, rx_addr_q, tx_addr_q};

    // Read-while-set latch and zero-write clear; ones are ignored
    assign seen_set = {5{rd_status}} & status_byte[7:3];
    assign clr_req  = {5{wr_status}} & ~wdata_q[7:3] & seen_q;

    // Config bits toward the rest of the unit
    assign tx_on     = config_q[`SSF_CFG_TX_ON];
    assign rx_on     = config_q[`SSF_CFG_RX_ON];
    assign sync_mode = config_q[`SSF_CFG_SYNC];
    assign tx_off    = ~tx_on;
    assign std_off   = standby;

    // Any pending error halts reception; sync mode stops transmit too
    assign rx_halt = overrun_q | framing_q | parity_q;
    assign tx_halt = sync_mode & rx_halt;

    // Receiver off or halted: new characters never reach the flags
    assign rx_active = rx_done & rx_on & ~rx_halt;

    // Raw character toward the checker
    assign rx_link.done       = rx_active;
    assign rx_link.char_data  = rx_char;
    assign rx_link.parity_bit = rx_parity_bit;
    assign rx_link.stop_bit   = rx_stop_bit;
    assign rx_link.addr_bit   = rx_mpb;
    assign rx_link.sync_mode  = sync_mode;
    assign rx_link.par_on     = config_q[`SSF_CFG_PAR_ON];
    assign rx_link.par_odd    = config_q[`SSF_CFG_PAR_ODD];

    // Overrun takes precedence; faulty characters still get stored
    assign overrun_ev = rx_link.verdict.done & rx_full_q;
    assign store_ev   = rx_link.verdict.done & ~rx_full_q;
    assign full_ev    = store_ev & ~rx_link.verdict.framing
                      & ~rx_link.verdict.parity;

    ssf_rx_check u_check (
        .clock (clock),
        .reset (reset),
        .rx    (rx_link.check)
    );

    // Bus write path: hold each half until both are present
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            aw_q     <= 1'b0;
            awaddr_q <= '0;
            w_q      <= 1'b0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
            bvalid_q <= 1'b0;
            bresp_q  <= `SSF_RESP_OKAY;
        end else begin
            if (s_axi_awvalid & ~aw_q) begin
                aw_q     <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_q <= 1'b0;
            end
            if (s_axi_wvalid & ~w_q) begin
                w_q     <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_q <= 1'b0;
            end
            // Unmapped writes are answered with an error, no effect
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_mapped ? `SSF_RESP_OKAY : `SSF_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Bus read path: data captured in the cycle the address is taken
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= `SSF_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_status ? {24'h0, status_byte}
                      : (s_axi_araddr == `SSF_CONFIG_OFS) ? {24'h0, config_q}
                      : 32'h0;
            rresp_q  <= rd_mapped ? `SSF_RESP_OKAY : `SSF_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Configuration register, untouched by standby
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            config_q <= `SSF_CONFIG_RST;
        end else if (wr_config) begin
            config_q <= wdata_q[7:0];
        end
    end

    // Transmit flags; clearing tx-empty also ends tx-finished
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            tx_empty_q <= 1'b1;
            tx_done_q  <= 1'b1;
            tx_addr_q  <= 1'b0;
        end else if (std_off) begin
            tx_empty_q <= 1'b1;
            tx_done_q  <= 1'b1;
            tx_addr_q  <= 1'b0;
        end else begin
            tx_empty_q <= flag_next(tx_empty_q, tx_off | tx_load,
                                    clr_req[7]);
            tx_done_q  <= flag_next(tx_done_q,
                                    tx_off | (tx_last_bit & tx_empty_q),
                                    clr_req[7]);
            if (wr_status) begin
                tx_addr_q <= wdata_q[`SSF_TX_ADDR_BIT];
            end
        end
    end

    // Receive flags; read-only address bit follows stored characters in multiprocessor mode
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rx_full_q <= 1'b0;
            overrun_q <= 1'b0;
            framing_q <= 1'b0;
            parity_q  <= 1'b0;
            rx_addr_q <= 1'b0;
        end else if (std_off) begin
            rx_full_q <= 1'b0;
            overrun_q <= 1'b0;
            framing_q <= 1'b0;
            parity_q  <= 1'b0;
            rx_addr_q <= 1'b0;
        end else begin
            rx_full_q <= flag_next(rx_full_q, full_ev, clr_req[6]);
            overrun_q <= flag_next(overrun_q, overrun_ev,
                                   clr_req[5]);
            framing_q <= flag_next(framing_q,
                                   store_ev & rx_link.verdict.framing,
                                   clr_req[4]);
            parity_q  <= flag_next(parity_q,
                                   store_ev & rx_link.verdict.parity,
                                   clr_req[3]);
            if (store_ev & config_q[`SSF_CFG_MULTI]) begin
                rx_addr_q <= rx_link.verdict.addr_bit;
            end
        end
    end

    // Read-observed latches; a new observation beats a clear
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            seen_q <= '0;
        end else if (std_off) begin
            seen_q <= '0;
        end else begin
            seen_q <= seen_set | (seen_q & ~clr_req);
        end
    end

    // Receive data register; overrun keeps the earlier character
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rx_data_q <= 8'h00;
        end else if (store_ev) begin
            rx_data_q <= rx_link.verdict.char_data;
        end
    end

    // Outputs
    assign s_axi_bvalid    = bvalid_q;
    assign s_axi_bresp     = bresp_q;
    assign s_axi_rvalid    = rvalid_q;
    assign s_axi_rdata     = rdata_q;
    assign s_axi_rresp     = rresp_q;
    assign rx_data         = rx_data_q;
    assign tx_addr_flag    = tx_addr_q;
    assign tx_buffer_empty = tx_empty_q;

endmodule // ssf_status

/* verif/ssf_status_chk.sv */
`timescale 1ns/1ps
module ssf_status_chk (
    // Clock, reset and standby
    input wire logic       clock,
    input wire logic       reset,
    input wire logic       standby,
    // Write answer
    input wire logic       s_axi_bvalid,
    // Line events
    input wire logic       tx_load,
    input wire logic       rx_done,
    input wire logic       rx_stop_bit,
    // State toward the line logic
    input wire logic [7:0] rx_data,
    input wire logic       rx_halt,
    input wire logic       tx_halt,
    input wire logic       tx_on,
    input wire logic       rx_on,
    input wire logic       sync_mode,
    input wire logic       tx_addr_flag,
    input wire logic       tx_buffer_empty
);
    // One domain, so one clock and one disable for all
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    // Transmit halt exactly when a receive error in sync mode
    chk_tx_halt_cause: assert property (tx_halt |-> sync_mode && rx_halt)
        else $error("transmit halt without sync receive error");
    chk_sync_halt: assert property (sync_mode && rx_halt |-> tx_halt)
        else $error("sync receive error left transmit running");
    // Transmit buffer empty after a load or while off
    chk_load_empty: assert property (tx_load |=> tx_buffer_empty)
        else $error("shift load left buffer marked full");
    chk_off_empty: assert property (!tx_on |=> tx_buffer_empty)
        else $error("disabled transmitter shows buffer full");
    // Standby forces the initial status
    chk_standby_init: assert property (standby |=>
        tx_buffer_empty && !rx_halt && !tx_addr_flag)
        else $error("standby did not restore status");
    // Refused characters must not touch the data register
    chk_halt_keep: assert property (rx_done && rx_halt |-> ##2 $stable(rx_data))
        else $error("halted receiver changed data");
    chk_off_keep: assert property (rx_done && !rx_on |-> ##2 $stable(rx_data))
        else $error("disabled receiver changed data");
    // Zero stop bit in async mode ends in a halt
    chk_frame_halt: assert property (rx_done && rx_on && !rx_halt
        && !sync_mode && !rx_stop_bit |-> ##3 rx_halt)
        else $error("framing fault did not halt reception");
    // Error flags drop only by a write or standby
    chk_halt_clear: assert property ($fell(rx_halt)
        |-> s_axi_bvalid || $past(standby))
        else $error("error flag dropped without clear");
endmodule // ssf_status_chk

/* verif/ssf_line_model.sv */
`timescale 1ns/1ps
module ssf_line_model (
    // Clock from the bench
    input  wire logic  clock,
    // Transmit shift register events
    output logic       tx_load,
    output logic       tx_last_bit,
    // Finished characters from the remote station
    output logic       rx_done,
    output logic [7:0] rx_char,
    output logic       rx_parity_bit,
    output logic       rx_stop_bit,
    output logic       rx_mpb
);
    // Idle at time zero
    initial begin
        tx_load = 1'b0;
        tx_last_bit = 1'b0;
        rx_done = 1'b0;
        rx_char = 8'h00;
        rx_parity_bit = 1'b0;
        rx_stop_bit = 1'b1;
        rx_mpb = 1'b0;
    end

    // One-cycle transmit pulse, then a short gap
    task automatic tx_event(input logic load, input logic last);
        @(posedge clock);
        tx_load <= load;
        tx_last_bit <= last;
        @(posedge clock);
        tx_load <= 1'b0;
        tx_last_bit <= 1'b0;
        repeat (2) @(posedge clock);
    endtask

    // One character; data lines invert once released
    task automatic send(input logic [7:0] c, input logic p, input logic s);
        @(posedge clock);
        rx_done <= 1'b1;
        rx_char <= c;
        rx_parity_bit <= p;
        rx_stop_bit <= s;
        rx_mpb <= p;
        @(posedge clock);
        rx_done <= 1'b0;
        rx_char <= ~c;
        rx_parity_bit <= ~p;
        rx_stop_bit <= ~s;
        rx_mpb <= ~p;
        // Verdict lands one edge after the character, flags the next
        repeat (3) @(posedge clock);
    endtask
endmodule // ssf_line_model

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    // Clock, reset and standby
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        standby = 1'b0;
    // Bus master side; only the low strobe bit matters
    logic [3:0]  s_axi_awaddr = 4'h0;
    logic        s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h1;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic [3:0]  s_axi_araddr = 4'h0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    // Slave answers
    wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire logic        s_axi_arready, s_axi_rvalid, tx_halt;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    // Line side
    wire logic        tx_load, tx_last_bit, rx_done;
    wire logic        rx_parity_bit, rx_stop_bit, rx_mpb;
    wire logic [7:0]  rx_char, rx_data;
    // Tallies and last read
    int          n_fail = 0;
    int          check_count = 0;
    logic [7:0]  rd_byte;
    logic [1:0]  rd_resp;

    // Free-running clock, 10 ns period
    always #5 clock = ~clock;

    // Block under test
    ssf_status ssf_status_i (
        .clock(clock), .reset(reset), .standby(standby),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .tx_load(tx_load),
        .tx_last_bit(tx_last_bit), .rx_done(rx_done), .rx_char(rx_char),
        .rx_parity_bit(rx_parity_bit), .rx_stop_bit(rx_stop_bit),
        .rx_mpb(rx_mpb), .rx_data(rx_data), .rx_halt(), .tx_halt(tx_halt),
        .tx_on(), .rx_on(), .sync_mode(), .tx_addr_flag(),
        .tx_buffer_empty()
    );

    // Remote station and shift register events
    ssf_line_model ssf_line_model_i (
        .clock(clock), .tx_load(tx_load), .tx_last_bit(tx_last_bit),
        .rx_done(rx_done), .rx_char(rx_char), .rx_parity_bit(rx_parity_bit),
        .rx_stop_bit(rx_stop_bit), .rx_mpb(rx_mpb)
    );

    // Compare and tally; unknowns never match
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h, expected %h",
                     $time, got, exp);
        end
    endtask

    // One write; each channel held until its own ready
    task automatic axi_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check({30'h0, s_axi_bresp}, 32'h0);
    endtask

    // One read; data taken at the edge rvalid is seen
    task automatic axi_read(input logic [3:0] a);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rd_byte = s_axi_rdata[7:0];
        rd_resp = s_axi_rresp;
    endtask

    // Status read, which also arms the clear latches
    task automatic expect_status(input logic [7:0] e);
        axi_read(4'h0);
        check({24'h0, rd_byte}, {24'h0, e});
    endtask

    // Clears need a prior read; ones are ignored
    task automatic t_status_writes;
        axi_write(4'h4, 8'h01);
        axi_write(4'h0, 8'h00);
        expect_status(8'h84);
        axi_write(4'h0, 8'hff);
        expect_status(8'h85);
        axi_write(4'h0, 8'h00);
        expect_status(8'h00);
        axi_read(4'h8);
        check({22'h0, rd_resp, rd_byte}, 32'h200);
        $display("test status_writes done");
    endtask

    // Shift load and end of character
    task automatic t_tx_events;
        ssf_line_model_i.tx_event(1'b1, 1'b0);
        expect_status(8'h80);
        axi_write(4'h0, 8'h00);
        ssf_line_model_i.tx_event(1'b0, 1'b1);
        expect_status(8'h00);
        ssf_line_model_i.tx_event(1'b1, 1'b0);
        ssf_line_model_i.tx_event(1'b0, 1'b1);
        expect_status(8'h84);
        axi_write(4'h0, 8'h00);
        axi_write(4'h4, 8'h00);
        expect_status(8'h84);
        $display("test tx_events done");
    endtask

    // Overrun, halt and receiver disable
    task automatic t_rx_overrun;
        axi_write(4'h4, 8'h22);
        ssf_line_model_i.send(8'ha5, 1'b1, 1'b1);
        expect_status(8'hc6);
        check({24'h0, rx_data}, 32'ha5);
        ssf_line_model_i.send(8'h3c, 1'b0, 1'b1);
        expect_status(8'he6);
        ssf_line_model_i.send(8'h11, 1'b0, 1'b1);
        check({24'h0, rx_data}, 32'ha5);
        axi_write(4'h4, 8'h00);
        ssf_line_model_i.send(8'h22, 1'b0, 1'b1);
        expect_status(8'he6);
        check({24'h0, rx_data}, 32'ha5);
        axi_write(4'h0, 8'h00);
        expect_status(8'h86);
        $display("test rx_overrun done");
    endtask
    // Framing fault, then even and odd parity
    task automatic t_rx_errors;
        axi_write(4'h4, 8'h22);
        ssf_line_model_i.send(8'h5a, 1'b0, 1'b0);
        expect_status(8'h94);
        check({24'h0, rx_data}, 32'h5a);
        axi_write(4'h0, 8'h00);
        for (int i = 0; i < 2; i++) begin
            axi_write(4'h4, {3'h0, i[0], 4'ha});
            ssf_line_model_i.send(8'h01, 1'b0, 1'b1);
            expect_status(i[0] ? 8'hc4 : 8'h8c);
            check({24'h0, rx_data}, 32'h01);
            axi_write(4'h0, 8'h00);
        end
        expect_status(8'h84);
        $display("test rx_errors done");
    endtask

    // Sync overrun stops transmit; standby restores
    task automatic t_sync_standby;
        axi_write(4'h4, 8'h07);
        ssf_line_model_i.send(8'hc3, 1'b0, 1'b0);
        expect_status(8'hc4);
        ssf_line_model_i.send(8'h2d, 1'b0, 1'b1);
        expect_status(8'he4);
        check({31'h0, tx_halt}, 32'h1);
        @(posedge clock);
        standby <= 1'b1;
        repeat (2) @(posedge clock);
        standby <= 1'b0;
        expect_status(8'h84);
        check({24'h0, rx_data}, 32'hc3);
        check({31'h0, tx_halt}, 32'h0);
        $display("test sync_standby done");
    endtask
    // Counts, verdict and end of run
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Main sequence after four reset cycles
    initial begin
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        t_status_writes();
        t_tx_events();
        t_rx_overrun();
        t_rx_errors();
        t_sync_standby();
        wrap_up();
    end

    // Watchdog: tests need a few thousand ns, so 50 us is a hang
    initial begin
        #50000;
        n_fail++;
        wrap_up();
    end
endmodule // tb_top

// Checker on the block
bind ssf_status ssf_status_chk ssf_status_chk_i (
    .clock(clock), .reset(reset), .standby(standby),
    .s_axi_bvalid(s_axi_bvalid), .tx_load(tx_load), .rx_done(rx_done),
    .rx_stop_bit(rx_stop_bit), .rx_data(rx_data), .rx_halt(rx_halt),
    .tx_halt(tx_halt), .tx_on(tx_on), .rx_on(rx_on),
    .sync_mode(sync_mode), .tx_addr_flag(tx_addr_flag),
    .tx_buffer_empty(tx_buffer_empty)
);
